// ---- logic/hcct_timer.sv ----
// hcct_timer: hall capture/compare timer with byte register port.
// assumes pins arrive asynchronous to CLOCK; bus signals are synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "hcct_defines.svh"

module hcct_timer (
  // clock, reset, enable
  input  wire logic       CLOCK,
  input  wire logic       RST_N,
  input  wire logic       CE,
  // register port
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // sensor and clock pins
  input  wire logic       HALL_IN_A,
  input  wire logic       HALL_IN_B,
  input  wire logic       HALL_IN_C,
  input  wire logic       AUX_TRIGGER_PIN,
  input  wire logic       PWM_OUT_SIGNAL,
  // event outputs
  output logic            LATCH_IRQ,
  output logic            MATCH_IRQ
);

  ////////////////////////////////////////////////////////////////////////////

  hcct_pkg::hcct_state_s r;
  hcct_pkg::hcct_state_s next_r;

  logic       on;
  logic       pause;
  logic [2:0] ck_code;
  logic [6:0] ck_mask;
  logic       tick;
  logic       src;
  logic       stb;
  logic       rise;
  logic       fall;
  logic       edge_ok;
  logic       capt;
  logic       match;
  logic       zero_req;
  logic       wr_ctl0;
  logic       on_start;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_r = r;

    on      = r.ctl0[`HCCT_B_ON];
    pause   = r.ctl0[`HCCT_B_PAUSE];
    ck_code = r.ctl0[`HCCT_B_CK_HI:`HCCT_B_CK_LO];
    wr_ctl0 = WR && (ADDR == `HCCT_A_CTL0);
    // the clear happens at the write itself, so the stale count is
    // never compared or captured after the restart
    on_start = wr_ctl0 && WDATA[`HCCT_B_ON] && !on;

    // pins: two flops before any use
    next_r.sy1 = {PWM_OUT_SIGNAL, AUX_TRIGGER_PIN,
                  HALL_IN_C, HALL_IN_B, HALL_IN_A};
    next_r.sy2 = r.sy1;

    // count clock: prescaler free runs so divided ticks stay evenly spaced
    next_r.pre      = r.pre + 7'h01;
    next_r.pwm_prev = r.sy2[4];
    ck_mask = 7'((8'h01 << ck_code) - 8'h01);
    if (ck_code == 3'h0) begin
      tick = r.sy2[4] && !r.pwm_prev;
    end else begin
      tick = ((r.pre & ck_mask) == ck_mask);
    end

    // trigger source
    case (r.ctl0[`HCCT_B_SRC_HI:`HCCT_B_SRC_LO])
      2'h0:    src = r.sy2[0];
      2'h1:    src = r.sy2[1];
      2'h2:    src = r.sy2[2];
      2'h3:    src = r.sy2[3];
      default: src = 1'b0;
    endcase

    // noise filter
    if (r.ctl1[`HCCT_B_NFS]) begin
      stb = (r.sdiv == `HCCT_SLOW_DIV);
    end else begin
      stb = 1'b1;
    end
    next_r.sdiv = r.sdiv + 2'h1;
    if (stb) begin
      next_r.samp = {r.samp[2:0], src};
    end
    if (!r.ctl1[`HCCT_B_FIL]) begin
      next_r.lvl = src;
    end else if (stb) begin
      if (r.ctl1[`HCCT_B_NFT]) begin
        if (next_r.samp == 4'hF || next_r.samp == 4'h0) begin
          next_r.lvl = next_r.samp[0];
        end
      end else begin
        if (next_r.samp[1] == next_r.samp[0]) begin
          next_r.lvl = next_r.samp[0];
        end
      end
    end
    next_r.lvl_prev = r.lvl;

    // edge select
    rise = r.lvl && !r.lvl_prev;
    fall = !r.lvl && r.lvl_prev;
    case (r.ctl1[`HCCT_B_EDGE_HI:`HCCT_B_EDGE_LO])
      2'h0:    edge_ok = 1'b0;
      2'h1:    edge_ok = rise;
      2'h2:    edge_ok = fall;
      2'h3:    edge_ok = rise || fall;
      default: edge_ok = 1'b0;
    endcase

    // events only while on
    capt  = on && r.ctl1[`HCCT_B_TEN] && edge_ok;
    match = on && (r.cnt == r.cmp);

    zero_req = (capt && r.ctl1[`HCCT_B_CLR_LATCH])
            || (match && r.ctl1[`HCCT_B_CLR_MATCH]);

    // counter
    if (on_start) begin
      next_r.cnt = 16'h0000;
    end else if (on) begin
      if (zero_req) begin
        next_r.cnt = 16'h0000;
      end else if (tick && !pause) begin
        // plain wrap from all ones
        next_r.cnt = r.cnt + 16'h0001;
      end
    end

    // capture
    if (capt) begin
      next_r.cap = r.cnt;
    end

    // sticky flags: a set in the clearing cycle wins
    next_r.flag[`HCCT_B_FLAG_CAPT] = capt
      || (r.flag[`HCCT_B_FLAG_CAPT]
      && !(WR && ADDR == `HCCT_A_EVT && WDATA[`HCCT_B_FLAG_CAPT]));
    next_r.flag[`HCCT_B_FLAG_MATCH] = match
      || (r.flag[`HCCT_B_FLAG_MATCH]
      && !(WR && ADDR == `HCCT_A_EVT && WDATA[`HCCT_B_FLAG_MATCH]));

    // register writes
    if (WR) begin
      case (ADDR)
        `HCCT_A_CTL0: begin
          next_r.ctl0 = WDATA & `HCCT_CTL0_WMASK;
        end
        `HCCT_A_CTL1: begin
          next_r.ctl1 = WDATA;
        end
        `HCCT_A_CMPL: begin
          next_r.cmp[7:0] = WDATA;
        end
        `HCCT_A_CMPH: begin
          next_r.cmp[15:8] = WDATA;
        end
        `HCCT_A_EVT: begin
          next_r.ien = WDATA[`HCCT_B_IEN_HI:`HCCT_B_IEN_LO];
        end
        default: begin
        end
      endcase
    end

    // register reads: data stands only in the cycle after the strobe
    next_r.rdata = `HCCT_RST_BYTE;
    if (RD) begin
      case (ADDR)
        `HCCT_A_CTL0: next_r.rdata = r.ctl0;
        `HCCT_A_CTL1: next_r.rdata = r.ctl1;
        `HCCT_A_CNTL: next_r.rdata = r.cnt[7:0];
        `HCCT_A_CNTH: next_r.rdata = r.cnt[15:8];
        `HCCT_A_CMPL: next_r.rdata = r.cmp[7:0];
        `HCCT_A_CMPH: next_r.rdata = r.cmp[15:8];
        `HCCT_A_CAPL: next_r.rdata = r.cap[7:0];
        `HCCT_A_CAPH: next_r.rdata = r.cap[15:8];
        `HCCT_A_EVT:  next_r.rdata = {2'h0, r.ien, 2'h0, r.flag};
        default:      next_r.rdata = `HCCT_RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // capture pair resets to zero too: an async reset may only load
  // constants, and zero is as good as unknown to software
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      r <= '0;
    end else if (CE) begin
      r <= next_r;
    end
  end

  assign RDATA     = r.rdata;
  assign LATCH_IRQ = r.flag[`HCCT_B_FLAG_CAPT] && r.ien[0];
  assign MATCH_IRQ = r.flag[`HCCT_B_FLAG_MATCH] && r.ien[1];

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  chk_count_up_step: assert property (
    (CE && on && !pause && tick && !zero_req && !WR)
    |=> (r.cnt == $past(r.cnt) + 16'h0001)
  ) else $error("counter did not step by one on a tick");

  chk_div_tick_full: assert property (
    (ck_code == 3'h7 && tick) |-> (r.pre == `HCCT_ALL_ONES)
  ) else $error("divide by 128 tick off its prescaler slot");

  chk_pause_hold: assert property (
    (CE && on && pause && !zero_req && !WR)
    |=> $stable(r.cnt)
  ) else $error("counter moved while paused");

  chk_on_rise_zero: assert property (
    (CE && on_start) |=> (r.cnt == 16'h0000) && on
  ) else $error("turning on did not clear the counter");

  // one cycle per attempt: a restart write in the cycle after is legal
  chk_off_hold_cnt: assert property (
    (CE && !on && !WR) |=> $stable(r.cnt)
  ) else $error("counter moved while off");

  chk_gate_no_capt: assert property (
    !r.ctl1[`HCCT_B_TEN] |-> !capt
  ) else $error("capture while trigger input disabled");

  chk_capt_latch_val: assert property (
    (CE && capt) |=> (r.cap == $past(r.cnt))
  ) else $error("capture pair missed the counter value");

  chk_latch_clear: assert property (
    (CE && capt && r.ctl1[`HCCT_B_CLR_LATCH] && !WR)
    |=> (r.cnt == 16'h0000)
  ) else $error("counter not cleared after capture");

  chk_match_clear: assert property (
    (CE && match && r.ctl1[`HCCT_B_CLR_MATCH] && !WR)
    |=> (r.cnt == 16'h0000)
  ) else $error("counter not cleared on compare match");

  chk_flag_capt_set: assert property (
    (CE && capt) |=> r.flag[`HCCT_B_FLAG_CAPT]
  ) else $error("capture flag not set");

  chk_flag_match_irq: assert property (
    (CE && match && r.ien[1] && !WR) |=> MATCH_IRQ
  ) else $error("match interrupt not raised");

  chk_rsvd_bit_zero: assert property (
    (CE && RD && ADDR == `HCCT_A_CTL0) |=> !RDATA[2]
  ) else $error("reserved control bit read back non-zero");

  chk_rdata_one_cycle: assert property (
    (CE && RD && ADDR == `HCCT_A_CNTL) |=> (RDATA == $past(r.cnt[7:0]))
  ) else $error("counter low byte read wrong");

endmodule

`default_nettype wire

// ---- logic/hcct_defines.svh ----
// hcct_defines.svh: register map, field positions and counts for the
// hall capture/compare timer; assumes CLOCK is the 125 MHz system clock.
//
// Contract
// - 16-bit counter counts up once per selected tick while on and running.
// - clock code 0 picks pwm output; codes 1..7 pick clock/2 .. clock/128.
// - pause holds the count unless a clear on latch or match zeroes it; un-pausing resumes from the held value.
// - timer_on rising clears and starts the count; falling stops and holds.
// - source code picks hall a, hall b, hall c or the aux trigger pin.
// - edge code: 0 off, 1 rising, 2 falling, 3 both edges capture.
// - trigger input enable low blocks every capture from the source.
// - filtered level accepted after 2 or 4 identical consecutive samples.
// - filter sample period is one clock, or four clocks when bit set.
// - filter enable off takes edges straight from the selected input.
// - clear_on_latch zeroes the counter right after a capture.
// - clear_on_match zeroes the counter when it equals the compare value.
// - counter is compared against the 16-bit compare value continuously while on.
// - each valid trigger latches the counter into the capture pair.
// - counter readable as low and high bytes, zero after reset.
// - compare value in two writable bytes, zero after reset.
// - capture value in two read-only bytes, undefined until first capture.
// - bit 2 of the first control register reads zero, ignores writes.
// - a capture sets a sticky flag; with its enable set, interrupt raised.
// - a match sets a sticky flag; with its enable set, interrupt raised.
`ifndef HCCT_DEFINES_SVH
`define HCCT_DEFINES_SVH

// register offsets
`define HCCT_A_CTL0       4'h0
`define HCCT_A_CTL1       4'h1
`define HCCT_A_CNTL       4'h2
`define HCCT_A_CNTH       4'h3
`define HCCT_A_CMPL       4'h4
`define HCCT_A_CMPH       4'h5
`define HCCT_A_CAPL       4'h6
`define HCCT_A_CAPH       4'h7
`define HCCT_A_EVT        4'h8

// timer_control_clock fields
`define HCCT_B_PAUSE      7
`define HCCT_B_CK_HI      6
`define HCCT_B_CK_LO      4
`define HCCT_B_ON         3
`define HCCT_B_SRC_HI     1
`define HCCT_B_SRC_LO     0
`define HCCT_CTL0_WMASK   8'hFB

// capture_filter_control fields
`define HCCT_B_EDGE_HI    7
`define HCCT_B_EDGE_LO    6
`define HCCT_B_TEN        5
`define HCCT_B_NFT        4
`define HCCT_B_NFS        3
`define HCCT_B_FIL        2
`define HCCT_B_CLR_LATCH  1
`define HCCT_B_CLR_MATCH  0

// event register fields
`define HCCT_B_FLAG_CAPT  0
`define HCCT_B_FLAG_MATCH 1
`define HCCT_B_IEN_LO     4
`define HCCT_B_IEN_HI     5

// reset values and timing counts
`define HCCT_RST_BYTE     8'h00
`define HCCT_SLOW_DIV     2'h3
`define HCCT_ALL_ONES     7'h7F

`endif

// ---- logic/hcct_pkg.sv ----
// hcct_pkg: state type of the hall capture/compare timer.
// assumes the defines header is compiled alongside.
`default_nettype none
package hcct_pkg;

  typedef struct packed {
    logic [7:0]  ctl0;
    logic [7:0]  ctl1;
    logic [15:0] cmp;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [6:0]  pre;
    logic [4:0]  sy1;
    logic [4:0]  sy2;
    logic        pwm_prev;
    logic [3:0]  samp;
    logic [1:0]  sdiv;
    logic        lvl;
    logic        lvl_prev;
    logic [1:0]  flag;
    logic [1:0]  ien;
    logic [7:0]  rdata;
  } hcct_state_s;

endpackage

`default_nettype wire

// ---- sim/hcct_hall_model.sv ----
// hcct_hall_model: hall sensors, aux trigger pin and free running pwm.
// assumes the bench calls drive() from one thread, right after an edge.
`timescale 1ns/1ps
`default_nettype none

module hcct_hall_model (
  // clock
  input  wire logic CLOCK,
  // sensor and pwm pins
  output logic      HALL_IN_A,
  output logic      HALL_IN_B,
  output logic      HALL_IN_C,
  output logic      AUX_TRIGGER_PIN,
  output logic      PWM_OUT_SIGNAL
);
  logic [3:0] pin = 4'h0;
  logic [2:0] div = 3'h0;
  logic       pwm = 1'b0;

  assign HALL_IN_A       = pin[0];
  assign HALL_IN_B       = pin[1];
  assign HALL_IN_C       = pin[2];
  assign AUX_TRIGGER_PIN = pin[3];
  assign PWM_OUT_SIGNAL  = pwm;

  // pwm never stops, ten-cycle period, as the motor drive keeps it going
  always @(posedge CLOCK) begin
    div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
    if (div == 3'h4) begin
      pwm <= ~pwm;
    end
  end

  // change one pin at the caller's edge, then hold it for width cycles;
  // no extra edge here, so a pulse is exactly width cycles wide
  task automatic drive(input int idx, input logic lvl, input int width);
    pin[idx] <= lvl;
    repeat (width) @(posedge CLOCK);
  endtask
endmodule

`default_nettype wire

// ---- sim/test_hall_capture_compare_timer.sv ----
// test_hall_capture_compare_timer: self-checking bench for hcct_timer.
// assumes the hall model drives all pins; CE drops once to show the freeze.
`timescale 1ns/1ps
`default_nettype none
`include "hcct_defines.svh"

module test_hall_capture_compare_timer;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] addr  = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic       ce    = 1'b1;
  logic [7:0] rdata;
  logic       ha, hb, hc, aux, pwm, latch_irq, match_irq;
  int         n_errors = 0;
  int         total_checks = 0;

  always #4 clock = ~clock;

  hcct_timer DUT (.CLOCK(clock), .RST_N(rst_n), .CE(ce), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .HALL_IN_A(ha),
    .HALL_IN_B(hb), .HALL_IN_C(hc), .AUX_TRIGGER_PIN(aux),
    .PWM_OUT_SIGNAL(pwm), .LATCH_IRQ(latch_irq), .MATCH_IRQ(match_irq));
  hcct_hall_model u_hall (.CLOCK(clock), .HALL_IN_A(ha), .HALL_IN_B(hb),
    .HALL_IN_C(hc), .AUX_TRIGGER_PIN(aux), .PWM_OUT_SIGNAL(pwm));

  //////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    // read data stand in this cycle; take them at its closing edge
    @(posedge clock);
    d = rdata;
  endtask

  // counts read live drift by up to three ticks with bus latency
  function automatic logic [15:0] near(input logic [15:0] s, e);
    return 16'((s + 16'h0003 >= e) && (s <= e + 16'h0003));
  endfunction

  task automatic t_regs();
    logic [7:0] d;
    for (int a = 0; a < 10; a++) begin
      rd_reg(a[3:0], d);
      check(16'(d), 16'h0000);
    end
    wr_reg(`HCCT_A_CTL0, 8'hF7);
    rd_reg(`HCCT_A_CTL0, d);
    check(16'(d), 16'h00F3);
    wr_reg(`HCCT_A_CTL0, 8'h00);
    wr_reg(`HCCT_A_CNTL, 8'h5A);
    rd_reg(`HCCT_A_CNTL, d);
    check(16'(d), 16'h0000);
    wr_reg(`HCCT_A_CMPL, 8'h5A);
    wr_reg(`HCCT_A_CMPH, 8'hA5);
    rd_reg(`HCCT_A_CMPL, d);
    check(16'(d), 16'h005A);
    rd_reg(`HCCT_A_CMPH, d);
    check(16'(d), 16'h00A5);
    $display("test regs done");
  endtask

  task automatic t_rates();
    logic [7:0] lo, hi;
    for (int k = 0; k < 8; k++) begin
      wr_reg(`HCCT_A_CTL0, 8'h00);
      wr_reg(`HCCT_A_CTL0, {1'b0, k[2:0], 4'h8});
      repeat (256) @(posedge clock);
      rd_reg(`HCCT_A_CNTL, lo);
      rd_reg(`HCCT_A_CNTH, hi);
      check(near({hi, lo}, k == 0 ? 16'h001A : 16'h0102 >> k),
            16'h0001);
    end
    $display("test rates done");
  endtask

  task automatic t_pause();
    logic [7:0] a, b;
    wr_reg(`HCCT_A_CTL0, 8'h00);
    wr_reg(`HCCT_A_CTL0, 8'h18);
    repeat (40) @(posedge clock);
    wr_reg(`HCCT_A_CTL0, 8'h98);
    rd_reg(`HCCT_A_CNTL, a);
    repeat (40) @(posedge clock);
    rd_reg(`HCCT_A_CNTL, b);
    check(16'(b), 16'(a));
    wr_reg(`HCCT_A_CTL0, 8'h18);
    repeat (40) @(posedge clock);
    rd_reg(`HCCT_A_CNTL, b);
    check(near(16'(b), 16'(a) + 16'h0016), 16'h0001);
    wr_reg(`HCCT_A_CTL0, 8'h10);
    rd_reg(`HCCT_A_CNTL, a);
    repeat (40) @(posedge clock);
    rd_reg(`HCCT_A_CNTL, b);
    check(16'(b), 16'(a));
    wr_reg(`HCCT_A_CTL0, 8'h18);
    rd_reg(`HCCT_A_CNTL, b);
    check(near(16'(b), 16'h0001), 16'h0001);
    rd_reg(`HCCT_A_CNTL, a);
    ce <= 1'b0;
    repeat (40) @(posedge clock);
    ce <= 1'b1;
    rd_reg(`HCCT_A_CNTL, b);
    check(near(16'(b), 16'(a) + 16'h0002), 16'h0001);
    $display("test pause done");
  endtask

  task automatic t_capture();
    logic [7:0] c, d;
    for (int s = 0; s < 4; s++) begin
      for (int e = 0; e < 4; e++) begin
        wr_reg(`HCCT_A_CTL1, {e[1:0], 6'h20});
        wr_reg(`HCCT_A_CTL0, {6'h26, s[1:0]});
        rd_reg(`HCCT_A_CNTL, c);
        wr_reg(`HCCT_A_EVT, 8'h33);
        u_hall.drive(s, 1'b1, 12);
        rd_reg(`HCCT_A_EVT, d);
        check(16'(d[0]), 16'(e[0]));
        check(16'(latch_irq), 16'(e[0]));
        rd_reg(`HCCT_A_CAPL, d);
        if (e[0]) check(16'(d), 16'(c));
        wr_reg(`HCCT_A_EVT, 8'h33);
        u_hall.drive(s, 1'b0, 12);
        rd_reg(`HCCT_A_EVT, d);
        check(16'(d[0]), 16'(e[1]));
      end
    end
    wr_reg(`HCCT_A_CTL1, 8'h62);
    wr_reg(`HCCT_A_CTL0, 8'h18);
    repeat (30) @(posedge clock);
    wr_reg(`HCCT_A_CTL0, 8'h98);
    rd_reg(`HCCT_A_CNTL, c);
    u_hall.drive(0, 1'b1, 12);
    rd_reg(`HCCT_A_CAPL, d);
    check(16'(d), 16'(c));
    rd_reg(`HCCT_A_CNTL, d);
    check(16'(d), 16'h0000);
    u_hall.drive(0, 1'b0, 12);
    wr_reg(`HCCT_A_CTL1, 8'hC0);
    wr_reg(`HCCT_A_EVT, 8'h33);
    u_hall.drive(0, 1'b1, 12);
    u_hall.drive(0, 1'b0, 12);
    rd_reg(`HCCT_A_EVT, d);
    check(16'(d[0]), 16'h0000);
    wr_reg(`HCCT_A_CTL1, 8'hE0);
    wr_reg(`HCCT_A_CTL0, 8'h00);
    u_hall.drive(0, 1'b1, 12);
    u_hall.drive(0, 1'b0, 12);
    rd_reg(`HCCT_A_EVT, d);
    check(16'(d[0]), 16'h0000);
    $display("test capture done");
  endtask

  task automatic t_filter();
    logic [7:0] cfg [5] = '{8'h64, 8'h74, 8'h6C, 8'h7C, 8'h60};
    int         w [5] = '{1, 3, 3, 8, 1};
    logic [7:0] d;
    wr_reg(`HCCT_A_CTL0, 8'h18);
    for (int i = 0; i < 5; i++) begin
      wr_reg(`HCCT_A_CTL1, cfg[i]);
      wr_reg(`HCCT_A_EVT, 8'h33);
      u_hall.drive(0, 1'b1, w[i]);
      u_hall.drive(0, 1'b0, 30);
      rd_reg(`HCCT_A_EVT, d);
      check(16'(d[0]), 16'(i == 4));
      wr_reg(`HCCT_A_EVT, 8'h33);
      u_hall.drive(0, 1'b1, 30);
      u_hall.drive(0, 1'b0, 30);
      rd_reg(`HCCT_A_EVT, d);
      check(16'(d[0]), 16'h0001);
    end
    $display("test filter done");
  endtask

  task automatic t_compare();
    logic [7:0] lo, hi;
    wr_reg(`HCCT_A_CMPL, 8'h05);
    wr_reg(`HCCT_A_CMPH, 8'h01);
    wr_reg(`HCCT_A_CTL1, 8'h01);
    wr_reg(`HCCT_A_CTL0, 8'h00);
    wr_reg(`HCCT_A_CTL0, 8'h18);
    wr_reg(`HCCT_A_EVT, 8'h33);
    repeat (700) @(posedge clock);
    rd_reg(`HCCT_A_CNTL, lo);
    rd_reg(`HCCT_A_CNTH, hi);
    check(16'({hi, lo} <= 16'h0105), 16'h0001);
    rd_reg(`HCCT_A_EVT, lo);
    check(16'(lo[1]), 16'h0001);
    check(16'(match_irq), 16'h0001);
    wr_reg(`HCCT_A_EVT, 8'h03);
    rd_reg(`HCCT_A_EVT, lo);
    check(16'(lo), 16'h0000);
    check(16'(match_irq), 16'h0000);
    $display("test compare done");
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_rates();
    t_pause();
    t_capture();
    t_filter();
    t_compare();
    finish_test();
  end

  // guard against a hung run
  initial begin
    repeat (30000) @(posedge clock);
    n_errors++;
    finish_test();
  end
endmodule

`default_nettype wire
